// file: core/lpsr_pkg.sv
package lpsr_pkg;
    // ----------------------------------------
    // command codes
    // ----------------------------------------
    localparam logic [7:0] LPSR_CMD_ENTRY    = 8'hB7;
    localparam logic [7:0] LPSR_CMD_PWR_ONE  = 8'hC0;
    localparam logic [7:0] LPSR_CMD_PWR_TWO  = 8'hC1;
    localparam logic [7:0] LPSR_CMD_SW_RESET = 8'h01;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int LPSR_BIAS_LSB    = 4;
    localparam int LPSR_STEP_LSB    = 0;
    localparam int LPSR_DSTBY_BIT   = 3;
    localparam int LPSR_GATE_BIT    = 2;
    localparam int LPSR_DISP_BIT    = 1;
    localparam int LPSR_LVD_BIT     = 0;
    localparam int LPSR_REFIN_LSB   = 0;
    localparam int LPSR_REFLVL_LSB  = 0;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [3:0] LPSR_STEP_RST   = 4'h0;
    localparam logic [2:0] LPSR_BIAS_RST   = 3'h1;
    localparam logic [2:0] LPSR_REFIN_RST  = 3'h1;
    localparam logic [5:0] LPSR_REFLVL_RST = 6'h26;
    localparam logic [3:0] LPSR_ENTRY_RST  = 4'h7;
    localparam logic [2:0] LPSR_WAKE_PULSES = 3'h6;
    // idle pin levels: data 0, ext 0, read 1, write 1, dc 0, cs 1
    localparam logic [12:0] LPSR_PIN_IDLE  = 13'h000D;
    // ----------------------------------------
    // gate output levels
    // ----------------------------------------
    localparam logic [1:0] LPSR_GATE_HIGH   = 2'h0;
    localparam logic [1:0] LPSR_GATE_LOW    = 2'h1;
    localparam logic [1:0] LPSR_GATE_NORMAL = 2'h2;
    typedef enum logic [3:0] {
        LPSR_SEL_NONE  = 4'h1,
        LPSR_SEL_ENTRY = 4'h2,
        LPSR_SEL_ONE   = 4'h4,
        LPSR_SEL_TWO   = 4'h8
    } lpsr_sel_t;
endpackage

// file: core/lpsr_regs.sv
// How it works
// - command C1h with select low on write rise picks power setting two
// - data byte: bit7 zero, bias in bits 6..4, step-up in 3..0
// - step-up bit 3 picks tripled versus doubled source rail, plus gate pair
// - bias code 000 halts amplifier; other codes small, medium or large
// - power setting two is taken only while extension enable is high
// - after power-on or software reset step-up is 0000, bias 001
// - after power-on deep standby 0, gate-on, display and detect-disable 1
// - software reset restores the same entry mode defaults
// - command C0h selects power setting one ahead of its parameters
// - after power-on reference input 001, reference level 100110
// - software reset restores reference input 001, level 100110
// - registers stay writable in every display mode, but take no writes in deep standby
// - deep standby left after six chip select falls or reset pin
// - gate outputs high, low or normal from gate-on and display bits
module lpsr_regs
    import lpsr_pkg::*;
#(
    parameter int SYNC_STAGES = 2,
    parameter int WAKE_PULSES = int'(LPSR_WAKE_PULSES)
)
(
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       chip_select_n,
    input  wire logic       command_data_select,
    input  wire logic       write_strobe_n,
    input  wire logic       read_strobe_n,
    input  wire logic [7:0] data_in,
    input  wire logic       extension_command_enable,
    output logic [3:0]      step_up_factor,
    output logic [2:0]      amp_bias_current,
    output logic            source_tripled,
    output logic [2:0]      reference_input_select,
    output logic [5:0]      reference_level_select,
    output logic            deep_standby_request,
    output logic            gate_on_select,
    output logic            display_drive_enable,
    output logic            low_voltage_detect_disable,
    output logic [1:0]      gate_level,
    output logic            amp_halted
);
    // ----------------------------------------
    // parameter checks
    // ----------------------------------------
    // one stage would let a metastable strobe reach the decode
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("lpsr_regs: SYNC_STAGES must be at least 2");
    end
    // the wake counter is four bits wide
    if (WAKE_PULSES < 1 || WAKE_PULSES > 15) begin : g_bad_wake
        $error("lpsr_regs: WAKE_PULSES must lie from 1 to 15");
    end

    // ----------------------------------------
    // local constants
    // ----------------------------------------
    localparam int         PIN_N     = 13;
    localparam logic [3:0] WAKE_LAST = 4'(WAKE_PULSES - 1);

    // ----------------------------------------
    // state and next values
    // ----------------------------------------
    lpsr_sel_t  sel_ff;
    lpsr_sel_t  nxt_sel;
    logic       one_phase_ff;
    logic       nxt_one_phase;
    logic [2:0] refin_ff;
    logic [2:0] nxt_refin;
    logic [5:0] reflvl_ff;
    logic [5:0] nxt_reflvl;
    logic [3:0] step_ff;
    logic [3:0] nxt_step;
    logic [2:0] bias_ff;
    logic [2:0] nxt_bias;
    logic       tripled_ff;
    logic       nxt_tripled;
    logic       halted_ff;
    logic       nxt_halted;
    logic       dstby_ff;
    logic       nxt_dstby;
    logic       gate_ff;
    logic       nxt_gate;
    logic       disp_ff;
    logic       nxt_disp;
    logic       lvd_ff;
    logic       nxt_lvd;
    logic [1:0] gate_lvl_ff;
    logic [1:0] nxt_gate_lvl;
    logic [3:0] wake_cnt_ff;
    logic [3:0] nxt_wake_cnt;
    logic       wr_prev_ff;
    logic       cs_prev_ff;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // data is synchronised alongside the strobe; host holds it across the edge
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_sync;

    assign pin_raw = {data_in, extension_command_enable, read_strobe_n, write_strobe_n,
                      command_data_select, chip_select_n};

    for (genvar gi = 0; gi < PIN_N; gi++) begin : g_sync
        logic [SYNC_STAGES-1:0] chain_ff;
        // reset to idle level so no false edge follows reset
        always_ff @(posedge core_clk) begin
            if (!nrst) begin
                chain_ff <= {SYNC_STAGES{LPSR_PIN_IDLE[gi]}};
            end else begin
                chain_ff <= {chain_ff[SYNC_STAGES-2:0], pin_raw[gi]};
            end
        end
        assign pin_sync[gi] = chain_ff[SYNC_STAGES-1];
    end

    wire       cs_n_s = pin_sync[0];
    wire       dc_s   = pin_sync[1];
    wire       wr_n_s = pin_sync[2];
    wire       rd_n_s = pin_sync[3];
    wire       ext_ok = pin_sync[4];
    wire [7:0] cmd    = pin_sync[12:5];

    // ----------------------------------------
    // edge detection
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wr_prev_ff <= 1'b1;
            cs_prev_ff <= 1'b1;
        end else begin
            wr_prev_ff <= wr_n_s;
            cs_prev_ff <= cs_n_s;
        end
    end

    // ----------------------------------------
    // strobe decode
    // ----------------------------------------
    wire wr_rise  = wr_n_s & ~wr_prev_ff;
    wire cs_fall  = ~cs_n_s & cs_prev_ff;
    wire take     = wr_rise & ~cs_n_s & rd_n_s;
    wire cmd_take = take & ~dc_s;
    wire par_take = take & dc_s;
    wire awake    = ~dstby_ff;

    wire sw_reset = cmd_take & awake & (cmd == LPSR_CMD_SW_RESET);
    // writes are gated by awake; no register accepts writes in deep standby
    wire wr_entry = par_take & awake & (sel_ff == LPSR_SEL_ENTRY);
    wire wr_one   = par_take & awake & (sel_ff == LPSR_SEL_ONE) & ext_ok;
    wire wr_two   = par_take & awake & (sel_ff == LPSR_SEL_TWO) & ext_ok;

    // settings are not held in deep standby, so a wake clears them all
    wire wake      = dstby_ff & cs_fall & (wake_cnt_ff == WAKE_LAST);
    wire clr_state = ~nrst | sw_reset | wake;

    // ----------------------------------------
    // command select
    // ----------------------------------------
    // a refused C1h clears the selection, so its parameter is dropped too
    always_comb begin
        nxt_sel = sel_ff;
        if (!awake) begin
            nxt_sel = LPSR_SEL_NONE;
        end else if (cmd_take) begin
            case (cmd)
                LPSR_CMD_ENTRY:   nxt_sel = LPSR_SEL_ENTRY;
                LPSR_CMD_PWR_ONE: nxt_sel = LPSR_SEL_ONE;
                LPSR_CMD_PWR_TWO: nxt_sel = ext_ok ? LPSR_SEL_TWO
                                                   : LPSR_SEL_NONE;
                default:          nxt_sel = LPSR_SEL_NONE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (clr_state) begin
            sel_ff <= LPSR_SEL_NONE;
        end else begin
            sel_ff <= nxt_sel;
        end
    end

    // ----------------------------------------
    // power setting one
    // ----------------------------------------
    // two bytes: input select, then level; further bytes alternate
    always_comb begin
        nxt_one_phase = one_phase_ff;
        if (cmd_take) begin
            nxt_one_phase = 1'b0;
        end else if (wr_one) begin
            nxt_one_phase = ~one_phase_ff;
        end
    end

    wire take_refin  = wr_one & ~one_phase_ff;
    wire take_reflvl = wr_one & one_phase_ff;

    assign nxt_refin  = take_refin ? cmd[LPSR_REFIN_LSB +: 3] : refin_ff;
    assign nxt_reflvl = take_reflvl ? cmd[LPSR_REFLVL_LSB +: 6] : reflvl_ff;

    always_ff @(posedge core_clk) begin
        if (clr_state) begin
            one_phase_ff <= 1'b0;
            refin_ff     <= LPSR_REFIN_RST;
            reflvl_ff    <= LPSR_REFLVL_RST;
        end else begin
            one_phase_ff <= nxt_one_phase;
            refin_ff     <= nxt_refin;
            reflvl_ff    <= nxt_reflvl;
        end
    end

    // ----------------------------------------
    // power setting two
    // ----------------------------------------
    wire [3:0] par_step = cmd[LPSR_STEP_LSB +: 4];
    wire [2:0] par_bias = cmd[LPSR_BIAS_LSB +: 3];

    assign nxt_step    = wr_two ? par_step : step_ff;
    assign nxt_bias    = wr_two ? par_bias : bias_ff;
    assign nxt_tripled = wr_two ? par_step[3] : tripled_ff;
    assign nxt_halted  = wr_two ? (par_bias == 3'h0) : halted_ff;

    always_ff @(posedge core_clk) begin
        if (clr_state) begin
            step_ff    <= LPSR_STEP_RST;
            bias_ff    <= LPSR_BIAS_RST;
            tripled_ff <= LPSR_STEP_RST[3];
            halted_ff  <= (LPSR_BIAS_RST == 3'h0);
        end else begin
            step_ff    <= nxt_step;
            bias_ff    <= nxt_bias;
            tripled_ff <= nxt_tripled;
            halted_ff  <= nxt_halted;
        end
    end

    // ----------------------------------------
    // entry mode and deep standby
    // ----------------------------------------
    wire [3:0] par_entry    = cmd[3:0];
    wire [1:0] par_gate_lvl = !par_entry[LPSR_GATE_BIT] ? LPSR_GATE_HIGH
                            : !par_entry[LPSR_DISP_BIT] ? LPSR_GATE_LOW
                            : LPSR_GATE_NORMAL;

    assign nxt_dstby    = wr_entry ? par_entry[LPSR_DSTBY_BIT] : dstby_ff;
    assign nxt_gate     = wr_entry ? par_entry[LPSR_GATE_BIT] : gate_ff;
    assign nxt_disp     = wr_entry ? par_entry[LPSR_DISP_BIT] : disp_ff;
    assign nxt_lvd      = wr_entry ? par_entry[LPSR_LVD_BIT] : lvd_ff;
    assign nxt_gate_lvl = wr_entry ? par_gate_lvl : gate_lvl_ff;
    // only chip select falls seen in standby count towards a wake
    assign nxt_wake_cnt = (dstby_ff && cs_fall) ? wake_cnt_ff + 4'h1 : wake_cnt_ff;

    always_ff @(posedge core_clk) begin
        if (clr_state) begin
            dstby_ff    <= LPSR_ENTRY_RST[LPSR_DSTBY_BIT];
            gate_ff     <= LPSR_ENTRY_RST[LPSR_GATE_BIT];
            disp_ff     <= LPSR_ENTRY_RST[LPSR_DISP_BIT];
            lvd_ff      <= LPSR_ENTRY_RST[LPSR_LVD_BIT];
            gate_lvl_ff <= LPSR_GATE_NORMAL;
            wake_cnt_ff <= 4'h0;
        end else begin
            dstby_ff    <= nxt_dstby;
            gate_ff     <= nxt_gate;
            disp_ff     <= nxt_disp;
            lvd_ff      <= nxt_lvd;
            gate_lvl_ff <= nxt_gate_lvl;
            wake_cnt_ff <= nxt_wake_cnt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign step_up_factor             = step_ff;
    assign amp_bias_current           = bias_ff;
    assign source_tripled             = tripled_ff;
    assign amp_halted                 = halted_ff;
    assign reference_input_select     = refin_ff;
    assign reference_level_select     = reflvl_ff;
    assign deep_standby_request       = dstby_ff;
    assign gate_on_select             = gate_ff;
    assign display_drive_enable       = disp_ff;
    assign low_voltage_detect_disable = lvd_ff;
    assign gate_level                 = gate_lvl_ff;
endmodule

// file: test/lpsr_regs_assertions.sv
module lpsr_regs_assertions
    import lpsr_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       chip_select_n,
    input wire logic       command_data_select,
    input wire logic       write_strobe_n,
    input wire logic       read_strobe_n,
    input wire logic [7:0] data_in,
    input wire logic       extension_command_enable,
    input wire logic [3:0] step_up_factor,
    input wire logic [2:0] amp_bias_current,
    input wire logic       source_tripled,
    input wire logic [2:0] reference_input_select,
    input wire logic [5:0] reference_level_select,
    input wire logic       deep_standby_request,
    input wire logic       gate_on_select,
    input wire logic       display_drive_enable,
    input wire logic       low_voltage_detect_disable,
    input wire logic [1:0] gate_level,
    input wire logic       amp_halted
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    AST_TRIPLED: assert property (source_tripled == step_up_factor[3])
        else $error("tripled flag wrong");
    AST_HALT: assert property (amp_halted == (amp_bias_current == 3'h0))
        else $error("halt flag wrong");
    AST_GATE: assert property (gate_level == (!gate_on_select ? LPSR_GATE_HIGH :
        display_drive_enable ? LPSR_GATE_NORMAL : LPSR_GATE_LOW)) else $error("gate level wrong");
    AST_RST_BOOST: assert property ($rose(nrst) |->
        step_up_factor == 4'h0 && amp_bias_current == 3'h1) else $error("boost default wrong");
    AST_RST_REF: assert property ($rose(nrst) |->
        reference_input_select == 3'h1 && reference_level_select == 6'h26) else $error("ref default");
    AST_RST_ENTRY: assert property ($rose(nrst) |-> !deep_standby_request &&
        gate_on_select && display_drive_enable && low_voltage_detect_disable) else $error("entry");
    AST_QUIET: assert property ((write_strobe_n && chip_select_n) [*8] |=>
        $stable(step_up_factor) && $stable(reference_level_select)) else $error("change w/o write");
    AST_EXT_OFF: assert property (!extension_command_enable [*8] |=>
        $stable(amp_bias_current)) else $error("write taken while extension off");
endmodule

// file: test/lpsr_host.sv
module lpsr_host (
    input  wire logic  core_clk,
    output logic       chip_select_n,
    output logic       command_data_select,
    output logic       write_strobe_n,
    output logic       read_strobe_n,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {chip_select_n, command_data_select, write_strobe_n, read_strobe_n} = 4'hF;
    initial data_in = 8'h00;
    // each strobe level held 4 clocks, above the 2 the synchroniser needs
    task automatic wr(input logic dc, input logic [7:0] d, input logic rd = 1'b1);
        @(posedge core_clk);
        chip_select_n <= 1'b0;
        command_data_select <= dc;
        data_in <= d;
        write_strobe_n <= 1'b0;
        read_strobe_n <= rd;
        repeat (4) @(posedge core_clk);
        write_strobe_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        chip_select_n <= 1'b1;
        read_strobe_n <= 1'b1;
        data_in <= ~d;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

// file: test/tb_top.sv
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_top
    import lpsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0, nrst = 1'b0, extension_command_enable = 1'b1;
    logic        chip_select_n, command_data_select, write_strobe_n, read_strobe_n;
    logic [7:0]  data_in;
    logic [3:0]  step_up_factor;
    logic [2:0]  amp_bias_current, reference_input_select;
    logic [5:0]  reference_level_select;
    logic [1:0]  gate_level;
    logic        source_tripled, deep_standby_request, gate_on_select, display_drive_enable;
    logic        low_voltage_detect_disable, amp_halted;
    int          num_errors = 0, comparisons = 0;
    wire  [3:0]  entry = {deep_standby_request, gate_on_select, display_drive_enable,
                          low_voltage_detect_disable};
    // ----------------------------------------
    // rows: parameter byte, step-up, bias; zero bias first
    // ----------------------------------------
    logic [14:0] rows [5] = '{{8'h05, 4'h5, 3'h0}, {8'h7F, 4'hF, 3'h7}, {8'h18, 4'h8, 3'h1},
                              {8'h4A, 4'hA, 3'h4}, {8'h53, 4'h3, 3'h5}};
    lpsr_regs u_lpsr_regs (.*);
    lpsr_host u_lpsr_host (.*);
    always #25 core_clk = ~core_clk;
    task automatic wr(input logic dc, input logic [7:0] d, input logic rd = 1'b1);
        u_lpsr_host.wr(dc, d, rd);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk_def(input string t);
        `CHK(step_up_factor, 4'h0)
        `CHK(amp_bias_current, 3'h1)
        `CHK({reference_input_select, reference_level_select}, 9'h066)
        `CHK(entry, 4'h7)
        $display("test %s done", t);
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk_def("reset");
        foreach (rows[i]) begin
            wr(1'b0, LPSR_CMD_PWR_TWO);
            wr(1'b1, rows[i][14:7]);
            `CHK(step_up_factor, rows[i][6:3])
            `CHK(amp_bias_current, rows[i][2:0])
            `CHK(source_tripled, rows[i][6])
            `CHK(amp_halted, rows[i][2:0] == 3'h0)
        end
        $display("test table done");
        wr(1'b1, 8'h22, 1'b0);
        `CHK(step_up_factor, 4'h3)
        $display("test read strobe done");
        extension_command_enable <= 1'b0;
        wr(1'b0, LPSR_CMD_PWR_TWO);
        wr(1'b1, 8'h22);
        `CHK(step_up_factor, 4'h3)
        $display("test extension off done");
        extension_command_enable <= 1'b1;
        wr(1'b0, LPSR_CMD_PWR_ONE);
        wr(1'b1, 8'h05);
        wr(1'b1, 8'h03);
        `CHK({reference_input_select, reference_level_select}, 9'h143)
        $display("test setting one done");
        wr(1'b0, LPSR_CMD_ENTRY);
        wr(1'b1, 8'h04);
        `CHK(gate_level, LPSR_GATE_LOW)
        wr(1'b0, LPSR_CMD_ENTRY);
        wr(1'b1, 8'h03);
        `CHK(gate_level, LPSR_GATE_HIGH)
        $display("test gate level done");
        wr(1'b0, LPSR_CMD_SW_RESET);
        chk_def("software reset");
        // non-default settings that the wake must wipe
        wr(1'b0, LPSR_CMD_PWR_TWO);
        wr(1'b1, 8'h7F);
        wr(1'b0, LPSR_CMD_ENTRY);
        wr(1'b1, 8'h0F);
        // five chip select falls must not wake, and their writes are dropped
        repeat (5) wr(1'b1, 8'h00);
        `CHK(deep_standby_request, 1'b1)
        wr(1'b0, 8'h00);
        chk_def("standby wake");
        wr(1'b0, LPSR_CMD_PWR_TWO);
        wr(1'b1, 8'h7F);
        `CHK(step_up_factor, 4'hF)
        nrst <= 1'b0;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk_def("mid-run reset");
        close_out();
    end
    // about 33 writes of 13 clocks each; 20000 clocks is ample margin
    initial begin
        #1000000;
        num_errors++;
        close_out();
    end
endmodule
bind lpsr_regs lpsr_regs_assertions u_lpsr_regs_assertions (.*);
